//--- design/dacc_code_control.sv
// dacc_code_control: register front end that feeds a 9-bit code to an r-2r array
// assumes one clock, synchronous active-low reset, and a single-cycle strobe port
// register map
//   74h  dac_control    bit 0 is converter_enable_bit, other bits read zero
//   75h  dac_code_high  code bits 8 down to 1
//   76h  dac_code_low   bit 7 is code bit 0, other bits read zero
//
// integration notes
// the block sits on the data-memory bus of the cpu; only three byte
// addresses are claimed, everything else reads back as zero.
// the r-2r array itself is analog and lives outside this module; it
// sees array_code and analog_output_pin_enable, both from flip-flops so
// the ladder switches never see decode glitches.
// the array is held at code zero while disabled; this costs nothing in
// software and keeps the ladder from sourcing current when parked.
// software must still clear the enable bit before stop or idle.
//
// hazards and limits
// a code change moves one register at a time, so a two-byte update shows
// an intermediate code on the ladder until the second write reaches it; software that cares
// should disable the converter around the update.
// clock enable low freezes the ladder code as well as the registers.
// reads have no side effects, so polling the code registers is harmless.
`timescale 1ns/1ps
`default_nettype none
module dacc_code_control
   import dacc_pkg::*;
(
   input  wire logic                        sys_clk,
   input  wire logic                        reset_n,
   input  wire logic                        clk_en,
   input  wire logic [dacc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [dacc_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_write,
   input  wire logic                        reg_read,
   output logic      [dacc_pkg::DATA_W-1:0] reg_rdata,
   output logic      [dacc_pkg::CODE_W-1:0] array_code,
   output logic                             analog_output_pin_enable
);
   import dacc_pkg::*;

   logic [DATA_W-1:0] control_reg, control_next;
   logic [DATA_W-1:0] code_high_reg, code_high_next;
   logic [DATA_W-1:0] code_low_reg, code_low_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [CODE_W-1:0] array_reg, array_next;
   logic              drive_reg, drive_next;
   logic [CODE_W-1:0] code_now;
   logic              hit_control, hit_high, hit_low, hit_any;
   logic              write_taken, read_taken;
   logic [CODE_W-1:0] gated_code;

   // address decode used only by the checks; the write and read paths decode reg_addr in their own case statements
   assign hit_control = reg_addr == DAC_CONTROL_ADDR;
   assign hit_high    = reg_addr == DAC_CODE_HIGH_ADDR;
   assign hit_low     = reg_addr == DAC_CODE_LOW_ADDR;
   assign hit_any     = hit_control || hit_high || hit_low;

   // a strobe only counts when the clock enable lets the registers move
   assign write_taken = reg_write && clk_en;
   assign read_taken  = reg_read && clk_en;

   // refuse package values that the bit packing below cannot serve
   if (CODE_W != DATA_W + 1) begin : g_bad_code_width
      $error("code width must be one more than the register width");
   end
   if (LOW_CODE_BIT >= DATA_W) begin : g_bad_low_bit
      $error("low code bit lies outside the low register");
   end
   if (ENABLE_BIT >= DATA_W) begin : g_bad_enable_bit
      $error("enable bit lies outside the control register");
   end

   // code as the array sees it; low register contributes only its top bit
   assign code_now = {code_high_reg, code_low_reg[LOW_CODE_BIT]};

   // per-bit gate between the registers and the ladder; each switch of the
   // array sees its own bit forced low while the converter is disabled
   for (genvar b = 0; b < CODE_W; b++) begin : g_code_gate
      assign gated_code[b] = code_now[b] & control_reg[ENABLE_BIT];
      // each ladder bit carries its gated register bit one edge later
      a_bit_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
         clk_en |=> array_code[b] == $past(gated_code[b]))
         else $error("ladder bit differs from gated code");
   end

   // register writes; unused bits are not stored so they read back as zero
   always_comb begin
      control_next   = control_reg;
      code_high_next = code_high_reg;
      code_low_next  = code_low_reg;
      if (reg_write) begin
         case (reg_addr)
            DAC_CONTROL_ADDR:   control_next   = reg_wdata & CONTROL_MASK;
            DAC_CODE_HIGH_ADDR: code_high_next = reg_wdata;
            DAC_CODE_LOW_ADDR:  code_low_next  = reg_wdata & CODE_LOW_MASK;
            default:            control_next   = control_reg;
         endcase
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_comb begin
      rdata_next = UNMAPPED_DATA;
      if (reg_read) begin
         case (reg_addr)
            DAC_CONTROL_ADDR:   rdata_next = control_reg;
            DAC_CODE_HIGH_ADDR: rdata_next = code_high_reg;
            DAC_CODE_LOW_ADDR:  rdata_next = code_low_reg;
            default:            rdata_next = UNMAPPED_DATA;
         endcase
      end
   end

   // array code follows the registers one cycle later; zero while disabled
   // so the r-2r ladder sinks no current when software turns it off
   always_comb begin
      drive_next = control_reg[ENABLE_BIT];
      array_next = gated_code;
   end

   // state registers, frozen while the clock enable is low
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         control_reg   <= CONTROL_RESET;
         code_high_reg <= CODE_RESET;
         code_low_reg  <= CODE_RESET;
         rdata_reg     <= UNMAPPED_DATA;
         array_reg     <= '0;
         drive_reg     <= 1'b0;
      end else if (clk_en) begin
         control_reg   <= control_next;
         code_high_reg <= code_high_next;
         code_low_reg  <= code_low_next;
         rdata_reg     <= rdata_next;
         array_reg     <= array_next;
         drive_reg     <= drive_next;
      end
   end

   assign reg_rdata                = rdata_reg;
   assign array_code               = array_reg;
   assign analog_output_pin_enable = drive_reg;

   // code seen by the array matches the high register two edges after a high write
   sequence s_code_write;
      reg_write && clk_en && reg_addr == DAC_CODE_HIGH_ADDR;
   endsequence
   a_high_write_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_code_write ##1 clk_en ##1 (control_reg[ENABLE_BIT] && $stable(control_reg))
      |-> array_code[CODE_W-1:1] == code_high_reg)
      else $error("array code does not follow high register");

   a_disabled_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !analog_output_pin_enable |-> array_code == '0)
      else $error("array code nonzero while disabled");

   a_low_bit_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clk_en && control_reg[ENABLE_BIT]) |=> array_code[0] == $past(code_low_reg[LOW_CODE_BIT]))
      else $error("low code bit misplaced");

   a_reset_clears: assert property (@(posedge sys_clk)
      !reset_n |=> (code_high_reg == CODE_RESET && code_low_reg == CODE_RESET && array_code == '0))
      else $error("reset did not clear the code");

   a_control_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_read && clk_en && reg_addr == DAC_CONTROL_ADDR) |=> reg_rdata == $past(control_reg))
      else $error("control read data wrong");

   a_control_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_write && clk_en && reg_addr == DAC_CONTROL_ADDR)
      |=> control_reg[ENABLE_BIT] == $past(reg_wdata[ENABLE_BIT]))
      else $error("control write not stored");

   a_high_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_read && clk_en && reg_addr == DAC_CODE_HIGH_ADDR) |=> reg_rdata == $past(code_high_reg))
      else $error("high code read wrong");

   a_enable_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clk_en && control_reg[ENABLE_BIT]) |=> analog_output_pin_enable && array_code == $past(code_now))
      else $error("enabled converter not driven from code");

   // checks below run on sys_clk and, except a_reset_outputs, skip reset; most wait for clk_en,
   // since an edge with the enable low moves nothing at all
   // the written byte is compared two edges on, so a second write right
   // behind the first does not upset the check

   // the low register write reaches code bit 0 two edges after it is taken
   sequence s_low_write;
      write_taken && hit_low;
   endsequence
   sequence s_enabled_step;
      clk_en && control_reg[ENABLE_BIT];
   endsequence
   a_low_write_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_low_write ##1 s_enabled_step
      |=> array_code[0] == $past(reg_wdata[LOW_CODE_BIT], 2))
      else $error("array code does not follow low write");

   // same path for the high register, checked against the written byte
   a_high_write_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_code_write ##1 s_enabled_step
      |=> array_code[CODE_W-1:1] == $past(reg_wdata, 2))
      else $error("array code does not follow high write");

   // setting the enable bit turns the pin drive on after one more edge
   sequence s_enable_write;
      write_taken && hit_control && reg_wdata[ENABLE_BIT];
   endsequence
   a_enable_write_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_enable_write ##1 clk_en |=> analog_output_pin_enable)
      else $error("enable write did not drive the pin");

   // clearing the enable bit parks the ladder at code zero
   sequence s_disable_write;
      write_taken && hit_control && !reg_wdata[ENABLE_BIT];
   endsequence
   a_disable_write_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_disable_write ##1 clk_en |=> array_code == '0)
      else $error("disable write left a code on the ladder");

   // read data stand for one cycle only and fall back to zero
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clk_en && !reg_read) |=> reg_rdata == UNMAPPED_DATA)
      else $error("read data linger after the read");

   // reads leave every register as it was
   a_read_no_side: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_taken && !reg_write)
      |=> ($stable(control_reg) && $stable(code_high_reg) && $stable(code_low_reg)))
      else $error("read changed a register");

   // low register reads back only its stored top bit
   a_low_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_taken && hit_low) |=> reg_rdata == $past(code_low_reg))
      else $error("low code read wrong");

   // unused low register bits never show on the read port
   a_low_read_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_taken && hit_low) |=> (reg_rdata & ~CODE_LOW_MASK) == '0)
      else $error("low code read shows unused bits");

   // addresses outside the map read zero and leave the registers alone
   a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_taken && !hit_any) |=> reg_rdata == UNMAPPED_DATA)
      else $error("unmapped read not zero");

   a_unmapped_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (write_taken && !hit_any)
      |=> ($stable(control_reg) && $stable(code_high_reg) && $stable(code_low_reg)))
      else $error("unmapped write changed a register");

   // stored values follow the masks, so unused bits never become visible
   a_high_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (write_taken && hit_high) |=> code_high_reg == $past(reg_wdata))
      else $error("high code write not stored");

   a_low_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (write_taken && hit_low) |=> code_low_reg == ($past(reg_wdata) & CODE_LOW_MASK))
      else $error("low code write not stored");

   a_control_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (write_taken && hit_control) |=> control_reg == ($past(reg_wdata) & CONTROL_MASK))
      else $error("control write not masked");

   // the ladder code is the enabled register code of the edge before
   a_array_from_regs: assert property (@(posedge sys_clk) disable iff (!reset_n)
      clk_en |=> array_code == ($past(control_reg[ENABLE_BIT]) ? $past(code_now) : '0))
      else $error("ladder code not taken from the registers");

   // clock enable low freezes every register and the ladder code
   a_frozen_state: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !clk_en
      |=> ($stable(control_reg) && $stable(code_high_reg) && $stable(code_low_reg)
           && $stable(array_code) && $stable(reg_rdata)))
      else $error("state moved while the clock enable was low");

   // switching the enable off releases the pin drive on the next edge
   a_drive_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clk_en && !control_reg[ENABLE_BIT]) |=> !analog_output_pin_enable)
      else $error("pin still driven while disabled");

   // reset also parks the read port and the pin drive
   a_reset_outputs: assert property (@(posedge sys_clk)
      !reset_n |=> (reg_rdata == UNMAPPED_DATA && !analog_output_pin_enable
                    && control_reg == CONTROL_RESET))
      else $error("reset did not park the outputs");
endmodule : dacc_code_control
`default_nettype wire

//--- design/dacc_pkg.sv
// dacc_pkg: register map, field positions and reset values of the converter code block
// assumes a byte-wide register port addressed by data-memory address
package dacc_pkg;
   localparam int unsigned ADDR_W          = 8;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned CODE_W          = 9;
   localparam logic [7:0]  DAC_CONTROL_ADDR   = 8'h74;
   localparam logic [7:0]  DAC_CODE_HIGH_ADDR = 8'h75;
   localparam logic [7:0]  DAC_CODE_LOW_ADDR  = 8'h76;
   localparam int unsigned ENABLE_BIT      = 0;
   localparam int unsigned LOW_CODE_BIT    = 7;
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam logic [7:0]  CODE_RESET      = 8'h00;
   localparam logic [7:0]  CONTROL_MASK    = 8'h01;
   localparam logic [7:0]  CODE_LOW_MASK   = 8'h80;
   localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
endpackage : dacc_pkg

//--- verif/testbench.sv
// testbench: register-level checks of the converter code block
// assumes the design package and module are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dacc_pkg::*;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic [8:0] array_code;
   logic       analog_output_pin_enable;
   int         miscompares = 0;
   int         num_checks = 0;
   dacc_code_control dacc_code_control_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .array_code(array_code), .analog_output_pin_enable(analog_output_pin_enable));
   // 200 mhz system clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobes drop at the taking edge, so a following call leaves one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk({1'b0, reg_rdata}, {1'b0, exp});
   endtask : rd
   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h00);
      chk(array_code, 9'h000);
      wr(8'h75, 8'hA5);
      wr(8'h76, 8'hFF);
      settle();
      chk(array_code, 9'h000);
      wr(8'h74, 8'hFF);
      settle();
      chk(array_code, 9'h14B);
      chk({8'h00, analog_output_pin_enable}, 9'h001);
      rd(8'h74, 8'h01);
      rd(8'h76, 8'h80);
      rd(8'h75, 8'hA5);
      settle();
      chk({1'b0, reg_rdata}, 9'h000);
      rd(8'h77, 8'h00);
      wr(8'h77, 8'hFF);
      rd(8'h74, 8'h01);
      wr(8'h76, 8'h00);
      #1 chk(array_code, 9'h14B);
      settle();
      chk(array_code, 9'h14A);
      wr(8'h75, 8'hFF);
      wr(8'h76, 8'h80);
      settle();
      chk(array_code, 9'h1FF);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(8'h75, 8'h00);
      settle();
      chk(array_code, 9'h1FF);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      wr(8'h74, 8'h00);
      settle();
      chk(array_code, 9'h000);
      chk({8'h00, analog_output_pin_enable}, 9'h000);
      wr(8'h74, 8'h01);
      wr(8'h75, 8'h3C);
      settle();
      chk(array_code, 9'h079);
      // second reset in mid-run must clear the code again
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 chk(array_code, 9'h000);
      chk({8'h00, analog_output_pin_enable}, 9'h000);
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h00);
      print_verdict();
   end
   // watchdog well beyond the fewer than a hundred cycles the sequence needs
   initial begin
      #5000;
      miscompares++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
